// ==== ssp_pkg.sv ====
package ssp_pkg;

    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int CLK_HZ      = 40_000_000;
    localparam int DELAY_MS    = 20;
    localparam int DELAY_CYC   = CLK_HZ / 1000 * DELAY_MS;
    localparam int OVS         = 16;
    localparam int SVC_BAUD    = 9600;

    // ---------------------------------------------------------------
    // Register map
    // ---------------------------------------------------------------
    localparam logic [3:0] OFS_SVC_CFG = 4'h0;
    localparam logic [3:0] OFS_RS_CFG  = 4'h4;
    localparam logic [3:0] OFS_STATUS  = 4'h8;

    localparam int F_MODE    = 0;   // [1:0]
    localparam int F_CHK     = 2;
    localparam int F_DLY     = 3;
    localparam int F_BAUD    = 4;   // [6:4]
    localparam int F_FRAME   = 7;   // [8:7]
    localparam int F_ADDR    = 9;   // [13:9]

    // ---------------------------------------------------------------
    // Encodings and reset values
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_OFF                   = 2'h0,
        MODE_LEGACY_SLAVE_PROTOCOL = 2'h1,
        MODE_MODBUS_HIGH_WORD_FIRST = 2'h2,
        MODE_MODBUS_LOW_WORD_FIRST  = 2'h3
    } ssp_mode_e;

    localparam logic [2:0] BAUD_MAX    = 3'h6;
    localparam logic [2:0] BAUD_RST    = 3'h3;
    localparam logic [1:0] FRM_8N1     = 2'h0;
    localparam logic [1:0] FRM_7O1     = 2'h1;
    localparam logic [1:0] FRM_7E1     = 2'h2;
    localparam logic [4:0] ADDR_RST    = 5'h01;
    localparam logic [4:0] MB_ADDR_MAX = 5'h1f;
    localparam logic [4:0] LG_ADDR_MAX = 5'h09;
    localparam logic [7:0] FN_READ     = 8'h03;
    localparam logic [7:0] FN_WRITE    = 8'h10;

    function automatic int baud_rate(input logic [2:0] sel);
        case (sel)
            3'h0:    return 1200;
            3'h1:    return 2400;
            3'h2:    return 4800;
            3'h3:    return 9600;
            3'h4:    return 19200;
            3'h5:    return 38400;
            default: return 57600;
        endcase
    endfunction : baud_rate

    typedef struct packed {
        ssp_mode_e  mode;
        logic       chk_en;
        logic       dly_en;
        logic [4:0] own_addr;
    } ssp_cfg_s;

    typedef struct packed {
        logic       frame_end;
        logic [7:0] addr;
        logic [7:0] func;
        logic       chk_ok;
    } ssp_req_s;

    typedef struct packed {
        logic go;
        logic exc;
        logic tx_en;
        logic lo_first;
        logic chk_en;
        logic busy;
    } ssp_ans_s;

endpackage : ssp_pkg

// ==== ssp_top.sv ====
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/100ps
// Notes on behaviour
// - The service port offers off, legacy slave, Modbus high-word-first and Modbus low-word-first.
// - The RS-485 port offers the same four protocol settings.
// - A port set to off transmits nothing outside a configuration session.
// - In legacy mode the port only answers the master and never starts traffic.
// - The RS-485 port runs at one of 1200 to 57600 baud, 9600 after reset.
// - RS-485 framing is 8N1, 7O1 or 7E1, with 8N1 after reset.
// - In Modbus the RS-485 address is 1 to 31, 1 after reset, and only own frames are answered.
// - In legacy mode the RS-485 address is 0 to 9.
// - The legacy checksum is switchable per port, on after reset; off means none sent or checked.
// - Modbus answers follow at once, or 20 ms later when the delay is chosen; at once after reset.
// - A configuration session is accepted in any setting and the saved setting resumes after it; the RS-485 port answers it only at addresses 0 to 9.
// - High-word-first puts the upper word lower; low-word-first puts the lower word lower.
// - Modbus supports only function codes 0x03 and 0x10.
// - The service port is fixed at 9600 baud, 8 data bits, no parity, one stop bit.

module ssp_gate #(
    parameter int DLY = ssp_pkg::DELAY_CYC
) (
    input  wire logic            mclk,
    input  wire logic            srst,
    input  ssp_pkg::ssp_cfg_s    cfg,
    input  wire logic            session,
    input  ssp_pkg::ssp_req_s    req,
    output ssp_pkg::ssp_ans_s    ans
);
    typedef enum logic {GS_IDLE = 1'b0, GS_WAIT = 1'b1} ssp_gst_e;

    ssp_gst_e          st_q;
    logic [31:0]       cnt_q;
    ssp_pkg::ssp_mode_e mode;
    logic              is_mb;
    logic              is_lg;
    logic              accept;
    logic              fn_ok;

    // ---------------------------------------------------------------
    // Frame acceptance
    // ---------------------------------------------------------------
    always_comb begin
        mode  = session ? ssp_pkg::MODE_LEGACY_SLAVE_PROTOCOL : cfg.mode;
        is_mb = mode == ssp_pkg::MODE_MODBUS_HIGH_WORD_FIRST ||
                mode == ssp_pkg::MODE_MODBUS_LOW_WORD_FIRST;
        is_lg = mode == ssp_pkg::MODE_LEGACY_SLAVE_PROTOCOL;
        fn_ok = req.func == ssp_pkg::FN_READ ||
                req.func == ssp_pkg::FN_WRITE;
        accept = 1'b0;
        if (is_mb) begin
            accept = req.chk_ok && cfg.own_addr != 5'h00 &&
                     req.addr == {3'h0, cfg.own_addr};
        end else if (is_lg) begin
            accept = cfg.own_addr <= ssp_pkg::LG_ADDR_MAX &&
                     req.addr == {3'h0, cfg.own_addr} &&
                     (req.chk_ok || !cfg.chk_en);
        end
        accept = accept && req.frame_end && st_q == GS_IDLE;
    end

    // ---------------------------------------------------------------
    // Answer timing
    // ---------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            st_q   <= GS_IDLE;
            cnt_q  <= 32'h0000_0000;
            ans.go <= 1'b0;
            ans.exc <= 1'b0;
        end else begin
            ans.go <= 1'b0;
            unique case (st_q)
                GS_IDLE: begin
                    if (accept) begin
                        ans.exc <= is_mb && !fn_ok;
                        if (is_mb && cfg.dly_en) begin
                            st_q  <= GS_WAIT;
                            cnt_q <= 32'(DLY - 2);
                        end else begin
                            ans.go <= 1'b1;
                        end
                    end
                end
                GS_WAIT: begin
                    if (cnt_q == 32'h0000_0000) begin
                        st_q   <= GS_IDLE;
                        ans.go <= 1'b1;
                    end else begin
                        cnt_q <= cnt_q - 32'h0000_0001;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            ans.tx_en    <= 1'b0;
            ans.lo_first <= 1'b0;
            ans.chk_en   <= 1'b0;
            ans.busy     <= 1'b0;
        end else begin
            ans.tx_en    <= mode != ssp_pkg::MODE_OFF;
            ans.lo_first <= mode == ssp_pkg::MODE_MODBUS_LOW_WORD_FIRST;
            ans.chk_en   <= is_lg && cfg.chk_en;
            ans.busy     <= accept ? (is_mb && cfg.dly_en)
                          : (st_q == GS_WAIT && cnt_q != 32'h0000_0000);
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    logic [31:0] wait_q;
    always_ff @(posedge mclk) begin
        if (srst || st_q == GS_IDLE) begin
            wait_q <= 32'h0000_0000;
        end else begin
            wait_q <= wait_q + 32'h0000_0001;
        end
    end

    sequence s_req_taken;
        accept && !(is_mb && cfg.dly_en);
    endsequence

    a_off_stays_quiet: assert property (@(posedge mclk) disable iff (srst)
        mode == ssp_pkg::MODE_OFF && st_q == GS_IDLE |=> !ans.go && !ans.tx_en)
        else $error("answer or transmit while port off");
    a_immediate_answer: assert property (@(posedge mclk) disable iff (srst)
        s_req_taken |=> ans.go ##1 !ans.go)
        else $error("immediate answer not one cycle later");
    a_delay_length: assert property (@(posedge mclk) disable iff (srst)
        st_q == GS_WAIT && cnt_q == 32'h0000_0000 |-> wait_q == 32'(DLY - 2))
        else $error("answer delay length wrong");
    a_mb_addr_match: assert property (@(posedge mclk) disable iff (srst)
        req.frame_end && is_mb && req.addr != {3'h0, cfg.own_addr}
        && st_q == GS_IDLE |=> !ans.go && st_q == GS_IDLE)
        else $error("foreign modbus frame answered");
    a_legacy_range: assert property (@(posedge mclk) disable iff (srst)
        is_lg && cfg.own_addr > ssp_pkg::LG_ADDR_MAX |-> !accept)
        else $error("legacy frame taken with illegal address");
    a_cksum_gate: assert property (@(posedge mclk) disable iff (srst)
        is_lg && cfg.chk_en && !req.chk_ok |-> !accept)
        else $error("bad legacy checksum accepted");
    a_func_exception: assert property (@(posedge mclk) disable iff (srst)
        accept && is_mb && !fn_ok |=> ans.exc)
        else $error("unsupported function not flagged");
    a_session_talks: assert property (@(posedge mclk) disable iff (srst)
        session |=> ans.tx_en && !ans.lo_first)
        else $error("session not served in legacy form");
endmodule : ssp_gate

module ssp_top #(
    parameter int DELAY_CYCLES = ssp_pkg::DELAY_CYC
) (
    input  wire logic             mclk,
    input  wire logic             srst,
    input  wire logic [3:0]       reg_addr,
    input  wire logic [31:0]      reg_wdata,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    output logic      [31:0]      reg_rdata,
    input  wire logic             svc_session,
    input  ssp_pkg::ssp_req_s     svc_req,
    output ssp_pkg::ssp_ans_s     svc_ans,
    output logic                  svc_tick,
    input  wire logic             rs_session,
    input  ssp_pkg::ssp_req_s     rs_req,
    output ssp_pkg::ssp_ans_s     rs_ans,
    output logic                  rs_tick,
    output logic                  rs_seven_bits,
    output logic                  rs_parity_en,
    output logic                  rs_parity_odd
);
    ssp_pkg::ssp_cfg_s svc_cfg_q;
    ssp_pkg::ssp_cfg_s rs_cfg_q;
    logic [2:0]        baud_q;
    logic [1:0]        frame_q;
    logic [15:0]       svc_div_q;
    logic [15:0]       rs_div_q;
    logic [15:0]       rs_lim;

    // ---------------------------------------------------------------
    // Register writes
    // ---------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            svc_cfg_q <= '{ssp_pkg::MODE_LEGACY_SLAVE_PROTOCOL, 1'b1, 1'b0,
                           ssp_pkg::ADDR_RST};
            rs_cfg_q  <= '{ssp_pkg::MODE_MODBUS_HIGH_WORD_FIRST, 1'b1, 1'b0,
                           ssp_pkg::ADDR_RST};
            baud_q    <= ssp_pkg::BAUD_RST;
            frame_q   <= ssp_pkg::FRM_8N1;
        end else if (reg_wr) begin
            if (reg_addr == ssp_pkg::OFS_SVC_CFG) begin
                svc_cfg_q.mode   <= ssp_pkg::ssp_mode_e'(
                    reg_wdata[ssp_pkg::F_MODE +: 2]);
                svc_cfg_q.chk_en <= reg_wdata[ssp_pkg::F_CHK];
                svc_cfg_q.dly_en <= reg_wdata[ssp_pkg::F_DLY];
            end
            if (reg_addr == ssp_pkg::OFS_RS_CFG) begin
                rs_cfg_q.mode   <= ssp_pkg::ssp_mode_e'(
                    reg_wdata[ssp_pkg::F_MODE +: 2]);
                rs_cfg_q.chk_en <= reg_wdata[ssp_pkg::F_CHK];
                rs_cfg_q.dly_en <= reg_wdata[ssp_pkg::F_DLY];
                rs_cfg_q.own_addr <= reg_wdata[ssp_pkg::F_ADDR +: 5];
                if (reg_wdata[ssp_pkg::F_BAUD +: 3] <= ssp_pkg::BAUD_MAX) begin
                    baud_q <= reg_wdata[ssp_pkg::F_BAUD +: 3];
                end
                if (reg_wdata[ssp_pkg::F_FRAME +: 2] != 2'h3) begin
                    frame_q <= reg_wdata[ssp_pkg::F_FRAME +: 2];
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // Register reads
    // ---------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            reg_rdata <= 32'h0000_0000;
        end else begin
            reg_rdata <= 32'h0000_0000;
            if (reg_rd) begin
                unique case (reg_addr)
                    ssp_pkg::OFS_SVC_CFG: reg_rdata <= {28'h000_0000,
                        svc_cfg_q.dly_en, svc_cfg_q.chk_en, svc_cfg_q.mode};
                    ssp_pkg::OFS_RS_CFG:  reg_rdata <= {18'h0_0000,
                        rs_cfg_q.own_addr, frame_q, baud_q, rs_cfg_q.dly_en,
                        rs_cfg_q.chk_en, rs_cfg_q.mode};
                    ssp_pkg::OFS_STATUS:  reg_rdata <= {28'h000_0000,
                        rs_ans.busy, svc_ans.busy, rs_session, svc_session};
                    default:              reg_rdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ---------------------------------------------------------------
    // Oversample ticks (x16)
    // ---------------------------------------------------------------
    assign rs_lim = 16'(ssp_pkg::CLK_HZ /
                        (ssp_pkg::OVS * ssp_pkg::baud_rate(baud_q)) - 1);

    always_ff @(posedge mclk) begin
        if (srst || svc_div_q == 16'(ssp_pkg::CLK_HZ /
                (ssp_pkg::OVS * ssp_pkg::SVC_BAUD) - 1)) begin
            svc_div_q <= 16'h0000;
        end else begin
            svc_div_q <= svc_div_q + 16'h0001;
        end
        svc_tick <= !srst && svc_div_q == 16'h0000;
    end

    always_ff @(posedge mclk) begin
        if (srst || rs_div_q >= rs_lim) begin
            rs_div_q <= 16'h0000;
        end else begin
            rs_div_q <= rs_div_q + 16'h0001;
        end
        rs_tick <= !srst && rs_div_q == 16'h0000;
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            rs_seven_bits <= 1'b0;
            rs_parity_en  <= 1'b0;
            rs_parity_odd <= 1'b0;
        end else begin
            rs_seven_bits <= frame_q != ssp_pkg::FRM_8N1;
            rs_parity_en  <= frame_q != ssp_pkg::FRM_8N1;
            rs_parity_odd <= frame_q == ssp_pkg::FRM_7O1;
        end
    end

    ssp_gate #(.DLY(DELAY_CYCLES)) u_svc (
        .mclk    (mclk),
        .srst    (srst),
        .cfg     (svc_cfg_q),
        .session (svc_session),
        .req     (svc_req),
        .ans     (svc_ans)
    );

    ssp_gate #(.DLY(DELAY_CYCLES)) u_rs (
        .mclk    (mclk),
        .srst    (srst),
        .cfg     (rs_cfg_q),
        .session (rs_session),
        .req     (rs_req),
        .ans     (rs_ans)
    );

    a_reset_defaults: assert property (@(posedge mclk)
        srst |=> svc_cfg_q.mode == ssp_pkg::MODE_LEGACY_SLAVE_PROTOCOL
                 && baud_q == ssp_pkg::BAUD_RST && frame_q == ssp_pkg::FRM_8N1)
        else $error("reset defaults wrong");
endmodule : ssp_top

// ==== ssp_master.sv ====
`timescale 1ns/100ps
// ---------------------------------------------------------------
// Serial master stand-in for one port
// ---------------------------------------------------------------
module ssp_master (
    input  wire logic         mclk,
    output ssp_pkg::ssp_req_s req
);
    logic       pend;
    logic [7:0] p_addr;
    logic [7:0] p_func;
    logic       p_ok;

    initial begin
        pend = 1'b0;
        req  = '0;
    end

    // Only this side opens a frame; idle fields churn every cycle
    always @(posedge mclk) begin
        if (pend) begin
            req  <= {1'b1, p_addr, p_func, p_ok};
            pend <= 1'b0;
        end else begin
            req <= {1'b0, 17'($urandom)};
        end
    end

    // Called off the edge; returns just after the taking edge
    task automatic send(input logic [7:0] a, input logic [7:0] f,
                        input logic ok);
        p_addr = a;
        p_func = f;
        p_ok   = ok;
        pend   = 1'b1;
        @(posedge mclk);
        @(posedge mclk);
        #1;
    endtask : send
endmodule : ssp_master

// ==== serial_slave_port_setup_bench.sv ====
`timescale 1ns/100ps
// ---------------------------------------------------------------
// Port setup bench
// ---------------------------------------------------------------
module serial_slave_port_setup_bench;
    localparam int DLY = 20;
    logic              mclk;
    logic              srst;
    logic [3:0]        reg_addr;
    logic [31:0]       reg_wdata;
    logic              reg_wr;
    logic              reg_rd;
    logic [31:0]       reg_rdata;
    logic              svc_session;
    logic              rs_session;
    ssp_pkg::ssp_req_s svc_req;
    ssp_pkg::ssp_req_s rs_req;
    ssp_pkg::ssp_ans_s svc_ans;
    ssp_pkg::ssp_ans_s rs_ans;
    logic              svc_tick;
    logic              rs_tick;
    logic              rs_seven_bits;
    logic              rs_parity_en;
    logic              rs_parity_odd;
    int                num_errors;
    int                total_checks;
    int                md_s[2];
    int                ck_s[2];
    int                dl_s[2];
    int                own_s[2];
    int                ses_s[2];
    int                rates[7] = '{1200, 2400, 4800, 9600, 19200, 38400,
                                    57600};
    int                per_q[$];

    ssp_top #(.DELAY_CYCLES(DLY)) dut_u (
        .mclk(mclk), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .svc_session(svc_session),
        .svc_req(svc_req), .svc_ans(svc_ans), .svc_tick(svc_tick),
        .rs_session(rs_session), .rs_req(rs_req), .rs_ans(rs_ans),
        .rs_tick(rs_tick), .rs_seven_bits(rs_seven_bits),
        .rs_parity_en(rs_parity_en), .rs_parity_odd(rs_parity_odd)
    );
    ssp_master mst_svc (.mclk(mclk), .req(svc_req));
    ssp_master mst_rs (.mclk(mclk), .req(rs_req));

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    task automatic complete_run;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : complete_run

    task automatic chk(input logic [31:0] g, e, input string m);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %0t %s got %h want %h", $time, m, g, e);
        end
    endtask : chk

    ssp_pkg::ssp_ans_s an[2];
    assign an[0] = svc_ans;
    assign an[1] = rs_ans;

    task automatic step(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask : step

    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1;
        v = reg_rdata;
    endtask : rd

    task automatic cfg(input int p, md, ck, dl, bd, fr, ow);
        md_s[p]  = md;
        ck_s[p]  = ck;
        dl_s[p]  = dl;
        own_s[p] = p ? ow : 1;
        wr(p ? 4'h4 : 4'h0,
           32'(md + ck * 4 + dl * 8 + bd * 16 + fr * 128 + ow * 512));
        step(2);
        chk(32'(an[p].tx_en), 32'(md != 0 || ses_s[p]), "tx en");
        if (md >= 2)
            chk(32'(an[p].lo_first), 32'(md == 3), "order");
        if (md == 1)
            chk(32'(an[p].chk_en), 32'(ck), "chk en");
    endtask : cfg

    function automatic int acc(input int p, a, ok);
        if (ses_s[p] || md_s[p] == 1)
            return own_s[p] <= 9 && a == own_s[p] && (ok || !ck_s[p]);
        if (md_s[p] >= 2)
            return ok && own_s[p] != 0 && a == own_s[p];
        return 0;
    endfunction : acc

    task automatic wait_go(input int p, output int n);
        n = 1;
        while (an[p].go !== 1'b1 && n <= DLY + 3) begin
            step(1);
            n++;
        end
        if (an[p].go !== 1'b1)
            n = 0;
    endtask : wait_go

    task automatic frame(input int p, a, f, ok);
        int n;
        int mb;
        int e;
        mb = md_s[p] >= 2 && !ses_s[p];
        e  = acc(p, a, ok) ? ((mb && dl_s[p]) ? DLY : 1) : 0;
        if (p)
            mst_rs.send(8'(a), 8'(f), 1'(ok));
        else
            mst_svc.send(8'(a), 8'(f), 1'(ok));
        wait_go(p, n);
        chk(32'(n), 32'(e), "answer");
        if (e != 0 && mb)
            chk(32'(an[p].exc), 32'(f != 3 && f != 16), "exc");
    endtask : frame

    task automatic tick_per(input int p, output int n);
        for (int k = 0; k < 2; k++) begin
            n = 0;
            do begin
                step(1);
                n++;
            end while ((p ? rs_tick : svc_tick) !== 1'b1 && n < 5000);
        end
    endtask : tick_per

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    initial begin
        int n;
        logic [31:0] d;
        srst = 1'b1;
        reg_addr = 4'h0;
        reg_wdata = 32'h0000_0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        svc_session = 1'b0;
        rs_session = 1'b0;
        md_s = '{1, 2};
        ck_s = '{1, 1};
        dl_s = '{0, 0};
        own_s = '{1, 1};
        ses_s = '{0, 0};
        void'($urandom(86));
        repeat (12) @(posedge mclk);
        srst <= 1'b0;
        step(2);
        rd(4'h0, d);
        chk(d, 32'h0000_0005, "svc reset");
        rd(4'h4, d);
        chk(d, 32'h0000_0236, "rs reset");
        wr(4'hc, 32'hffff_ffff);
        rd(4'hc, d);
        chk(d, 32'h0000_0000, "unmapped");
        rd(4'h0, d);
        chk(d, 32'h0000_0005, "unmapped write");
        foreach (rates[i]) per_q.push_back(40_000_000 / (16 * rates[i]));
        for (int i = 0; i < 7; i++) begin
            cfg(1, 2, 1, 0, i, 0, 1);
            tick_per(1, n);
            chk(32'(n), 32'(per_q.pop_front()), "rs tick");
        end
        tick_per(0, n);
        chk(32'(n), 32'(40_000_000 / (16 * 9600)), "svc tick");
        for (int fr = 0; fr < 3; fr++) begin
            cfg(1, 2, 1, 0, 3, fr, 1);
            chk({29'h0, rs_seven_bits, rs_parity_en, rs_parity_odd},
                fr == 0 ? 0 : (fr == 1 ? 7 : 6), "framing");
        end
        wr(4'h4, 32'h0000_09f6);
        rd(4'h4, d);
        chk(d, 32'h0000_0936, "bad codes");
        for (int p = 0; p < 2; p++) begin
            for (int md = 0; md < 4; md++) begin
                cfg(p, md, $urandom % 2, $urandom % 2, 3, 0, $urandom % 11);
                repeat (6)
                    frame(p, ($urandom % 2) ? own_s[p] : $urandom % 11,
                          ($urandom % 3) ? (($urandom % 2) ? 3 : 16)
                                         : $urandom % 256,
                          $urandom % 4 != 0);
            end
        end
        cfg(1, 2, 1, 0, 3, 0, 31);
        frame(1, 31, 4, 1);
        cfg(1, 1, 0, 0, 3, 0, 9);
        frame(1, 9, 3, 0);
        cfg(1, 1, 1, 1, 3, 0, 9);
        frame(1, 9, 3, 0);
        frame(1, 9, 3, 1);
        cfg(1, 2, 1, 1, 3, 0, 1);
        mst_rs.send(8'h01, 8'h03, 1'b1);
        step(4);
        chk(32'(rs_ans.busy), 32'h0000_0001, "busy");
        rd(4'h8, d);
        chk(d, 32'h0000_0008, "status busy");
        mst_rs.send(8'h01, 8'h03, 1'b1);
        wait_go(1, n);
        chk(32'(n), 32'(DLY - 8), "delay");
        step(1);
        wait_go(1, n);
        chk(32'(n), 32'h0000_0000, "busy drop");
        cfg(1, 0, 1, 0, 3, 0, 1);
        @(posedge mclk);
        rs_session <= 1'b1;
        ses_s[1] = 1;
        step(2);
        chk(32'(rs_ans.tx_en), 32'h0000_0001, "session tx");
        rd(4'h8, d);
        chk(d, 32'h0000_0002, "status session");
        frame(1, 1, 3, 1);
        @(posedge mclk);
        rs_session <= 1'b0;
        ses_s[1] = 0;
        step(2);
        chk(32'(rs_ans.tx_en), 32'h0000_0000, "resume");
        rd(4'h4, d);
        chk(d, 32'h0000_0234, "saved mode");
        frame(1, 1, 3, 1);
        cfg(0, 0, 1, 0, 0, 0, 0);
        frame(0, 1, 3, 1);
        complete_run();
    end

    initial begin
        repeat (60000) @(posedge mclk);
        num_errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        complete_run();
    end
endmodule : serial_slave_port_setup_bench
